// ### rtl/jnpe_ctrl.sv
// Operation
// R1 - Enter: reset register gets 1, then the key register gets the key.
// R2 - Leave: no-op command, zero key, then 0 into the reset register.
// R3 - No-op is two command words and precedes disabling programming.
// R4 - Erase sends four words, then polls until the status bit is 1.
// R5 - Page programming is refused unless a chip erase completed first.
// R6 - Word-wise flash writes use raw command words in the required order.
// R7 - Page load: address with word-in-page zero, fill chain, write, poll.
// R8 - Device page fill chain is one page long, byte-buffered internally.
// R9 - Page bits go first word LSB first, last word MSB last.
// R10 - Page dump chain is page plus 8; first 8 bits are discarded.
// R11 - After priming, dump bytes come LSB first from first word onward.
// R12 - Fuse write entry word, then data-load opcode with fuse byte.
// R13 - High fuse write uses three words, then repeated poll word.
// R14 - Low fuse write uses three words, then repeated poll word.
// R15 - Device: fuse bit 0 programs, 1 unprograms.
// R16 - Lock write: entry, 11 plus six bits, three words, poll.
// R17 - Device: lock bit 0 programs, 1 leaves the bit unchanged.
// R18 - Polls repeat until the returned status bit reads 1.
// R19 - Fuse read entry, then two words return the low fuse byte.
// R20 - Combined fuse read returns high fuse, low fuse, lock in order.
// R21 - Id read: entry, address byte load, two words return the byte.
// R22 - Calibration read: entry, address byte, two words return the byte.
// R23 - Device accepts three-word sequences without their leading word.
// R24 - Device ignores address bits above its implemented top bits.
// R25 - Device held in reset while the reset register holds 1.
// R26 - Device key register is 16 bits; programming enabled on key match.
// R27 - Command register is 15 bits, returning the previous result.
// R28 - Device treats unknown command words as no operation.
`timescale 1ns/10ps
`include "jnpe_regs.svh"
module jnpe_ctrl #(
  parameter int HALF = 4, // Clocks per test clock half period, at least 3.
  parameter int PAGE_BITS = 1024, // Flash page size in bits, multiple of 8.
  parameter int WORD_BITS = 6, // Width of the word-in-page field.
  parameter int IR_LEN = 4, // Instruction register length.
  parameter logic [7:0] IR_RST_CODE = 8'h0c, // Reset select instruction.
  parameter logic [7:0] IR_KEY_CODE = 8'h04, // Key register instruction.
  parameter logic [7:0] IR_CMD_CODE = 8'h05, // Command instruction.
  parameter logic [7:0] IR_FILL_CODE = 8'h06, // Page fill instruction.
  parameter logic [7:0] IR_DUMP_CODE = 8'h07, // Page dump instruction.
  parameter int POLL_MAX = 10000 // Polls before giving up.
) (
  input wire logic clock, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic cmd_valid, // Operation request.
  input wire jnpe_pkg::jnpe_op_t cmd_op, // Operation code.
  input wire logic [15:0] cmd_arg, // Word, byte or page address.
  output logic cmd_ready, // Ready for an operation.
  output logic rsp_valid, // Returned word or byte, one-cycle pulse.
  output logic [14:0] rsp_data, // Returned data.
  output logic op_done, // Operation finished, one-cycle pulse.
  output logic op_fail, // Finished with refusal or poll timeout.
  input wire logic fill_valid, // Page fill byte offered.
  input wire logic [7:0] fill_data, // Page fill byte.
  output logic fill_ready, // Page fill byte may be taken.
  output logic tck, // Test clock, divided from clock.
  output logic tms, // Test mode select.
  output logic tdi, // Test data to the device.
  input wire logic tdo // Test data from the device.
);
  localparam int PW = $clog2(PAGE_BITS + 32) + 1;

  jnpe_pkg::jnpe_state_t st;
  jnpe_pkg::jnpe_op_t op_r;
  jnpe_pkg::jnpe_step_t step;
  logic [15:0] arg_r;
  logic [3:0] idx;
  logic [15:0] polls;
  logic erased;
  logic [7:0] ph;
  logic [PW-1:0] pos, hd, nb, total, k_cur, k_nxt;
  logic [15:0] sr, cap, next_sr, next_cap;
  logic next_tdi, need_byte, byte_done, fall_go, rise_go, scan_end;
  logic tdo_m, tdo_s, fill_full;
  logic [7:0] fill_hold;

  function automatic jnpe_pkg::jnpe_step_t mk(jnpe_pkg::jnpe_kind_t k,
      logic r, logic [15:0] d);
    jnpe_pkg::jnpe_step_t s;
    s.kind = k;
    s.resp = r;
    s.data = d;
    return s;
  endfunction : mk

  function automatic jnpe_pkg::jnpe_step_t cw(logic [14:0] w, logic r);
    return mk(jnpe_pkg::K_DR15, r, {1'b0, w});
  endfunction : cw

  function automatic jnpe_pkg::jnpe_step_t ir(logic [7:0] c);
    return mk(jnpe_pkg::K_IR, 1'b0, {8'h00, c});
  endfunction : ir

  function automatic logic in_sh(logic [PW-1:0] p, logic [PW-1:0] h,
      logic [PW-1:0] n);
    return (p >= h) && (p < PW'(h + n));
  endfunction : in_sh

  // Step table: every operation is a short list of tap scans.
  always_comb begin
    logic [7:0] lo;
    lo = arg_r[7:0] & ~8'((1 << WORD_BITS) - 1); // [R7]
    step = mk(jnpe_pkg::K_END, 1'b0, 16'h0000);
    case (op_r)
      jnpe_pkg::OP_ENTER: begin
        case (idx) // [R1]
          4'h0: step = mk(jnpe_pkg::K_RESET, 1'b0, 16'h0000);
          4'h1: step = ir(IR_RST_CODE);
          4'h2: step = mk(jnpe_pkg::K_DR1, 1'b0, 16'h0001);
          4'h3: step = ir(IR_KEY_CODE);
          4'h4: step = mk(jnpe_pkg::K_DR16, 1'b0, `JNPE_KEY);
          default: ;
        endcase
      end
      jnpe_pkg::OP_LEAVE: begin
        case (idx) // [R2] [R3]
          4'h0: step = ir(IR_CMD_CODE);
          4'h1: step = cw(`JNPE_W_NOP_A, 1'b0);
          4'h2: step = cw(`JNPE_W_NOP_B, 1'b0);
          4'h3: step = ir(IR_KEY_CODE);
          4'h4: step = mk(jnpe_pkg::K_DR16, 1'b0, 16'h0000);
          4'h5: step = ir(IR_RST_CODE);
          4'h6: step = mk(jnpe_pkg::K_DR1, 1'b0, 16'h0000);
          default: ;
        endcase
      end
      jnpe_pkg::OP_WORD: begin
        case (idx) // [R6]
          4'h0: step = ir(IR_CMD_CODE);
          4'h1: step = cw(arg_r[14:0], 1'b1);
          default: ;
        endcase
      end
      jnpe_pkg::OP_ERASE: begin
        case (idx) // [R4]
          4'h0: step = ir(IR_CMD_CODE);
          4'h1: step = cw(`JNPE_W_ERASE_A, 1'b0);
          4'h2: step = cw(`JNPE_W_ERASE_B, 1'b0);
          4'h3, 4'h4: step = cw(`JNPE_W_ERASE_C, 1'b0);
          4'h5: step = mk(jnpe_pkg::K_POLL, 1'b1, {1'b0, `JNPE_W_ERASE_C});
          default: ;
        endcase
      end
      jnpe_pkg::OP_FUSE_HI, jnpe_pkg::OP_FUSE_LO, jnpe_pkg::OP_LOCK: begin
        case (idx) // [R12] [R13] [R14] [R16]
          4'h0: step = ir(IR_CMD_CODE);
          4'h1: step = cw(op_r == jnpe_pkg::OP_LOCK ? `JNPE_W_LOCK_WR
                          : `JNPE_W_FUSE_WR, 1'b0);
          4'h2: step = cw({`JNPE_OP_DATA_LO, op_r == jnpe_pkg::OP_LOCK ?
                          {`JNPE_LOCK_PAD, arg_r[5:0]} : arg_r[7:0]}, 1'b0);
          4'h3, 4'h5: step = cw(op_r == jnpe_pkg::OP_FUSE_HI ? `JNPE_W_HI_A
                                : `JNPE_W_LO_A, 1'b0);
          4'h4: step = cw(op_r == jnpe_pkg::OP_FUSE_HI ? `JNPE_W_HI_B
                          : `JNPE_W_LO_B, 1'b0);
          4'h6: step = mk(jnpe_pkg::K_POLL, 1'b1, op_r == jnpe_pkg::OP_FUSE_HI
                          ? {1'b0, `JNPE_W_HI_A} : {1'b0, `JNPE_W_LO_A});
          default: ;
        endcase
      end
      jnpe_pkg::OP_READ_FUSES: begin
        case (idx) // [R19] [R20]
          4'h0: step = ir(IR_CMD_CODE);
          4'h1: step = cw(`JNPE_W_FUSE_RD, 1'b0);
          4'h2: step = cw(`JNPE_W_RD_FH, 1'b0);
          4'h3: step = cw(`JNPE_W_RD_A, 1'b1);
          4'h4: step = cw(`JNPE_W_RD_C, 1'b1);
          4'h5: step = cw(`JNPE_W_HI_A, 1'b1);
          default: ;
        endcase
      end
      jnpe_pkg::OP_READ_SIG, jnpe_pkg::OP_READ_CAL: begin
        case (idx) // [R21] [R22]
          4'h0: step = ir(IR_CMD_CODE);
          4'h1: step = cw(`JNPE_W_ID_RD, 1'b0);
          4'h2: step = cw({`JNPE_OP_ADDR_LO, arg_r[7:0]}, 1'b0);
          4'h3: step = cw(op_r == jnpe_pkg::OP_READ_SIG ? `JNPE_W_RD_A
                          : `JNPE_W_RD_C, 1'b0);
          4'h4: step = cw(op_r == jnpe_pkg::OP_READ_SIG ? `JNPE_W_LO_A
                          : `JNPE_W_HI_A, 1'b1);
          default: ;
        endcase
      end
      jnpe_pkg::OP_PAGE_WRITE, jnpe_pkg::OP_PAGE_READ: begin
        case (idx) // [R7]
          4'h0: step = ir(IR_CMD_CODE);
          4'h1: step = cw(op_r == jnpe_pkg::OP_PAGE_WRITE ? `JNPE_W_FLASH_WR
                          : `JNPE_W_FLASH_RD, 1'b0);
          4'h2: step = cw({`JNPE_OP_ADDR_HI, arg_r[15:8]}, 1'b0);
          4'h3: step = cw({`JNPE_OP_ADDR_LO, lo}, 1'b0);
          4'h4: step = ir(op_r == jnpe_pkg::OP_PAGE_WRITE ? IR_FILL_CODE
                          : IR_DUMP_CODE);
          4'h5: step = mk(op_r == jnpe_pkg::OP_PAGE_WRITE ? jnpe_pkg::K_FILL
                          : jnpe_pkg::K_DUMP, 1'b0, 16'h0000);
          4'h6: step = ir(IR_CMD_CODE);
          4'h7, 4'h9: step = op_r == jnpe_pkg::OP_PAGE_WRITE ?
                             cw(`JNPE_W_HI_A, 1'b0) : step;
          4'h8: step = op_r == jnpe_pkg::OP_PAGE_WRITE ?
                       cw(`JNPE_W_HI_B, 1'b0) : step;
          4'ha: step = op_r == jnpe_pkg::OP_PAGE_WRITE ?
                       mk(jnpe_pkg::K_POLL, 1'b1, {1'b0, `JNPE_W_HI_A}) : step;
          default: ;
        endcase
      end
      default: ;
    endcase
  end

  // Scan geometry of the current step; reset walk has no shift phase.
  always_comb begin
    hd = PW'(`JNPE_HEAD_DR_LEN);
    nb = PW'(`JNPE_CMD_BITS);
    total = PW'(`JNPE_TLR_LEN + 1);
    case (step.kind)
      jnpe_pkg::K_RESET: begin
        hd = '0;
        nb = '0;
      end
      jnpe_pkg::K_IR: hd = PW'(`JNPE_HEAD_IR_LEN);
      jnpe_pkg::K_DR1: nb = PW'(1);
      jnpe_pkg::K_DR16: nb = PW'(`JNPE_KEY_BITS);
      jnpe_pkg::K_FILL: nb = PW'(PAGE_BITS); // [R9]
      jnpe_pkg::K_DUMP: nb = PW'(PAGE_BITS + `JNPE_PRIME_BITS); // [R10]
      default: ;
    endcase
    if (step.kind == jnpe_pkg::K_IR) begin
      nb = PW'(IR_LEN);
    end
    if (step.kind != jnpe_pkg::K_RESET) begin
      total = PW'(hd + nb + PW'(`JNPE_TAIL_LEN));
    end
  end

  // Falling-edge data path: shift, capture, refill and next pin values.
  always_comb begin
    k_cur = PW'(pos - hd);
    k_nxt = PW'(pos + PW'(1) - hd);
    next_cap = in_sh(pos, hd, nb) ? {tdo_s, cap[15:1]} : cap;
    next_sr = in_sh(pos, hd, nb) ? {1'b0, sr[15:1]} : sr;
    need_byte = step.kind == jnpe_pkg::K_FILL &&
                in_sh(PW'(pos + PW'(1)), hd, nb) && k_nxt[2:0] == 3'h0;
    if (need_byte) begin
      next_sr = {8'h00, fill_hold}; // [R9]
    end
    next_tdi = in_sh(PW'(pos + PW'(1)), hd, nb) &&
               step.kind != jnpe_pkg::K_DUMP && next_sr[0];
    byte_done = step.kind == jnpe_pkg::K_DUMP && in_sh(pos, hd, nb) &&
                k_cur[2:0] == 3'h7 &&
                k_cur >= PW'(`JNPE_PRIME_BITS + `JNPE_BYTE_BITS - 1); // [R11]
    fall_go = st == jnpe_pkg::S_SCAN && tck && ph == 8'(HALF - 1) &&
              !(need_byte && !fill_full);
    rise_go = st == jnpe_pkg::S_SCAN && !tck && ph == 8'(HALF - 1) &&
              pos < total;
    scan_end = fall_go && PW'(pos + PW'(1)) == total;
  end

  // Two flops on the returned test data before anything reads it.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tdo_m <= 1'b0;
      tdo_s <= 1'b0;
    end else begin
      tdo_m <= tdo;
      tdo_s <= tdo_m;
    end
  end

  // Test clock divider; it stalls high when a fill byte is late.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ph <= 8'h00;
      tck <= 1'b0;
    end else if (st != jnpe_pkg::S_SCAN) begin
      ph <= 8'h00;
      tck <= 1'b0;
    end else if (rise_go || fall_go) begin
      ph <= 8'h00;
      tck <= ~tck;
    end else if (ph != 8'(HALF - 1)) begin
      ph <= ph + 8'h01;
    end
  end

  // Scan position, shift data and pins; pins change only with tck low.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pos <= '0;
      sr <= 16'h0000;
      cap <= 16'h0000;
      tms <= 1'b1;
      tdi <= 1'b0;
    end else if (st == jnpe_pkg::S_FETCH) begin
      pos <= '0;
      sr <= step.data;
      tms <= step.kind == jnpe_pkg::K_RESET ? 1'b1 :
             step.kind == jnpe_pkg::K_IR ? 1'(`JNPE_HEAD_IR) :
             1'(`JNPE_HEAD_DR);
      tdi <= 1'b0;
    end else if (fall_go) begin
      pos <= PW'(pos + PW'(1));
      sr <= next_sr;
      cap <= next_cap;
      tdi <= next_tdi;
      if (step.kind == jnpe_pkg::K_RESET) begin
        tms <= PW'(pos + PW'(1)) < PW'(`JNPE_TLR_LEN);
      end else if (PW'(pos + PW'(1)) < hd) begin
        tms <= step.kind == jnpe_pkg::K_IR ?
               1'(`JNPE_HEAD_IR >> (pos + PW'(1))) :
               1'(`JNPE_HEAD_DR >> (pos + PW'(1)));
      end else begin
        tms <= PW'(pos + PW'(1)) == PW'(hd + nb - PW'(1)) ||
               PW'(pos + PW'(1)) == PW'(hd + nb);
      end
    end
  end

  // One-byte holding stage between the fill port and the chain.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fill_full <= 1'b0;
      fill_hold <= 8'h00;
      fill_ready <= 1'b0;
    end else if (fill_valid && fill_ready) begin
      fill_full <= 1'b1;
      fill_hold <= fill_data;
      fill_ready <= 1'b0;
    end else begin
      if (fall_go && need_byte) begin
        fill_full <= 1'b0;
      end
      fill_ready <= !fill_full || (fall_go && need_byte);
    end
  end

  // Operation sequencer; a poll timeout or a refused write ends the op.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= jnpe_pkg::S_IDLE;
      op_r <= jnpe_pkg::OP_WORD;
      arg_r <= 16'h0000;
      idx <= 4'h0;
      polls <= 16'h0000;
      erased <= 1'b0;
      cmd_ready <= 1'b0;
      op_done <= 1'b0;
      op_fail <= 1'b0;
    end else begin
      op_done <= 1'b0;
      op_fail <= 1'b0;
      case (st)
        jnpe_pkg::S_IDLE: begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            op_r <= cmd_op;
            arg_r <= cmd_arg;
            idx <= 4'h0;
            polls <= 16'h0000;
            if (cmd_op == jnpe_pkg::OP_PAGE_WRITE && !erased) begin
              op_done <= 1'b1; // [R5]
              op_fail <= 1'b1;
            end else begin
              st <= jnpe_pkg::S_FETCH;
            end
          end
        end
        jnpe_pkg::S_FETCH: begin
          if (step.kind == jnpe_pkg::K_END) begin
            st <= jnpe_pkg::S_IDLE;
            op_done <= 1'b1;
            if (op_r == jnpe_pkg::OP_ERASE) begin
              erased <= 1'b1; // [R5]
            end else if (op_r == jnpe_pkg::OP_LEAVE ||
                         op_r == jnpe_pkg::OP_ENTER) begin
              erased <= 1'b0;
            end
          end else begin
            st <= jnpe_pkg::S_SCAN;
          end
        end
        jnpe_pkg::S_SCAN: begin
          if (scan_end) begin
            st <= jnpe_pkg::S_NEXT;
          end
        end
        jnpe_pkg::S_NEXT: begin
          st <= jnpe_pkg::S_FETCH;
          if (step.kind == jnpe_pkg::K_POLL &&
              !cap[`JNPE_POLL_BIT + 1]) begin
            polls <= polls + 16'h0001; // [R18]
            if (polls == 16'(POLL_MAX - 1)) begin
              st <= jnpe_pkg::S_IDLE;
              op_done <= 1'b1;
              op_fail <= 1'b1;
            end
          end else begin
            idx <= idx + 4'h1;
          end
        end
        default: st <= jnpe_pkg::S_IDLE;
      endcase
    end
  end

  // Returned words after each answering step, and dumped page bytes.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= 15'h0000;
    end else begin
      rsp_valid <= 1'b0;
      if (fall_go && byte_done) begin
        rsp_valid <= 1'b1; // [R11]
        rsp_data <= {7'h00, next_cap[15:8]};
      end else if (st == jnpe_pkg::S_NEXT && step.resp &&
                   (step.kind != jnpe_pkg::K_POLL ||
                    cap[`JNPE_POLL_BIT + 1])) begin
        rsp_valid <= 1'b1;
        rsp_data <= cap[15:1];
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_pins_low;
    $changed(tdi) || $changed(tms) |-> !tck;
  endproperty
  a_pins_low: assert property (p_pins_low) else $error("pin moved high"); // [R9]
  property p_key;
    st == jnpe_pkg::S_SCAN && step.kind == jnpe_pkg::K_DR16 && pos == '0
      |-> sr == (op_r == jnpe_pkg::OP_ENTER ? `JNPE_KEY : 16'h0000);
  endproperty
  a_key: assert property (p_key) else $error("wrong key scan"); // [R1]
  property p_leave_nop;
    op_r == jnpe_pkg::OP_LEAVE && st == jnpe_pkg::S_SCAN &&
      step.kind == jnpe_pkg::K_DR16 |-> idx == 4'h4;
  endproperty
  a_leave_nop: assert property (p_leave_nop) else $error("nop skipped"); // [R3]
  property p_poll_ok;
    st == jnpe_pkg::S_NEXT && step.kind == jnpe_pkg::K_POLL &&
      !cap[`JNPE_POLL_BIT + 1] |=> $stable(idx);
  endproperty
  a_poll_ok: assert property (p_poll_ok) else $error("poll advanced"); // [R18]
  property p_refuse;
    cmd_valid && cmd_ready && cmd_op == jnpe_pkg::OP_PAGE_WRITE && !erased
      |=> op_done && op_fail && st == jnpe_pkg::S_IDLE;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unerased write"); // [R5]
  property p_page_addr;
    op_r == jnpe_pkg::OP_PAGE_WRITE && st == jnpe_pkg::S_SCAN && idx == 4'h3
      && pos == '0 |-> sr[WORD_BITS-1:0] == '0;
  endproperty
  a_page_addr: assert property (p_page_addr) else $error("word field"); // [R7]
  property p_dump_skip;
    rsp_valid && step.kind == jnpe_pkg::K_DUMP
      |-> pos > PW'(hd + `JNPE_PRIME_BITS);
  endproperty
  a_dump_skip: assert property (p_dump_skip) else $error("prime byte"); // [R10]
  property p_dump_pair;
    rsp_valid && step.kind == jnpe_pkg::K_DUMP
      |=> !rsp_valid [*2] ##0 st == jnpe_pkg::S_SCAN;
  endproperty
  a_dump_pair: assert property (p_dump_pair) else $error("dump burst"); // [R11]
  property p_erase_poll;
    op_r == jnpe_pkg::OP_ERASE && st == jnpe_pkg::S_FETCH &&
      step.kind == jnpe_pkg::K_END |-> $past(cap[`JNPE_POLL_BIT + 1], 2);
  endproperty
  a_erase_poll: assert property (p_erase_poll) else $error("erase early"); // [R4]
  c_enter: cover property (op_done && op_r == jnpe_pkg::OP_ENTER);
  c_repoll: cover property (st == jnpe_pkg::S_NEXT &&
                            step.kind == jnpe_pkg::K_POLL && polls != '0);
  c_dump: cover property (rsp_valid && step.kind == jnpe_pkg::K_DUMP);
  c_fill: cover property (fall_go && need_byte);
endmodule : jnpe_ctrl

// ### rtl/jnpe_regs.svh
`ifndef JNPE_REGS_SVH
`define JNPE_REGS_SVH
// Enable key shifted into the key register to unlock programming.
`define JNPE_KEY 16'ha370
// Fifteen-bit command words, opcode in bits 14:8, operand in bits 7:0.
`define JNPE_W_NOP_A 15'h2300
`define JNPE_W_ERASE_A 15'h2380
`define JNPE_W_ERASE_B 15'h3180
`define JNPE_W_ERASE_C 15'h3380
`define JNPE_W_FLASH_WR 15'h2310
`define JNPE_W_FLASH_RD 15'h2302
`define JNPE_W_FUSE_WR 15'h2340
`define JNPE_W_LOCK_WR 15'h2320
`define JNPE_W_FUSE_RD 15'h2304
`define JNPE_W_ID_RD 15'h2308
`define JNPE_W_HI_A 15'h3700
`define JNPE_W_HI_B 15'h3500
`define JNPE_W_LO_A 15'h3300
`define JNPE_W_LO_B 15'h3100
`define JNPE_W_NOP_B `JNPE_W_LO_A
`define JNPE_W_RD_A 15'h3200
`define JNPE_W_RD_C 15'h3600
`define JNPE_W_RD_FH 15'h3e00
// Opcodes that carry an operand byte.
`define JNPE_OP_ADDR_HI 7'h07
`define JNPE_OP_ADDR_LO 7'h03
`define JNPE_OP_DATA_LO 7'h13
`define JNPE_LOCK_PAD 2'h3
// Completion flag position inside a returned command word.
`define JNPE_POLL_BIT 9
// Tap walk: head patterns are sent first bit first.
`define JNPE_HEAD_IR 4'h3
`define JNPE_HEAD_IR_LEN 4
`define JNPE_HEAD_DR 4'h1
`define JNPE_HEAD_DR_LEN 3
`define JNPE_TLR_LEN 5
`define JNPE_TAIL_LEN 2
`define JNPE_PRIME_BITS 8
`define JNPE_BYTE_BITS 8
`define JNPE_KEY_BITS 16
`define JNPE_CMD_BITS 15
`endif

// ### rtl/jnpe_pkg.sv
package jnpe_pkg;
  typedef enum logic [3:0] {
    OP_ENTER, OP_LEAVE, OP_WORD, OP_ERASE, OP_FUSE_HI, OP_FUSE_LO,
    OP_LOCK, OP_READ_FUSES, OP_READ_SIG, OP_READ_CAL, OP_PAGE_WRITE,
    OP_PAGE_READ
  } jnpe_op_t;
  typedef enum logic [3:0] {
    K_END, K_RESET, K_IR, K_DR1, K_DR16, K_DR15, K_POLL, K_FILL, K_DUMP
  } jnpe_kind_t;
  typedef struct packed {
    jnpe_kind_t kind;
    logic resp;
    logic [15:0] data;
  } jnpe_step_t;
  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_SCAN, S_NEXT} jnpe_state_t;
endpackage : jnpe_pkg

// ### test/jnpe_dev.sv
`timescale 1ns/10ps
`include "jnpe_regs.svh"
// Device model: tap, key, command word and page chains.
module jnpe_dev #(parameter int PB = 16) (
  input wire logic tck, // Test clock.
  input wire logic tms, // Mode select.
  input wire logic tdi, // Data in.
  output logic tdo, // Data out.
  output logic rst_reg, // Reset register.
  output logic en, // Key matches.
  output logic [14:0] last_cmd, // Last word.
  output logic [PB-1:0] pg // Page buffer.
);
  logic [3:0] ir, st;
  logic [PB+15:0] sh, out;
  logic [15:0] key;
  logic [14:0] res;
  logic [7:0] fh, fl, lk, db, ad, md, rb;
  int n, busy;
  initial begin
    st = 0; key = 0; lk = 8'hff; busy = 0; tdo = 0; rst_reg = 0;
  end
  assign en = key == `JNPE_KEY;
  // Tdo toggles outside shifts, so a stale bit is never read as data.
  always @(negedge tck) tdo <= (st == 5 || st == 9) ? out[n] : ~tdo;
  // Unknown words fall through every test; they still set last_cmd and the result word and count busy down.
  task automatic take(input logic [14:0] w);
    last_cmd <= w;
    if (w[14:8] == `JNPE_OP_DATA_LO) db = w[7:0];
    if (w[14:8] == `JNPE_OP_ADDR_LO) ad = w[7:0];
    if (w[14:8] == 7'h23) md = w[7:0];
    if (w == `JNPE_W_HI_B) fh = db;
    if (w == `JNPE_W_LO_B && md == 8'h40) fl = db;
    if (w == `JNPE_W_LO_B && md == 8'h20) lk = lk & db;
    if (w == `JNPE_W_HI_B || w == `JNPE_W_LO_B || w == `JNPE_W_ERASE_B)
      busy = 2;
    // The answer to this word leaves during the next scan.
    rb = w == `JNPE_W_RD_FH ? fh : w == `JNPE_W_RD_C ?
      (md[3] ? 8'h96 : lk) : w == `JNPE_W_RD_A ?
      (md[3] ? ad ^ 8'h5a : fl) : 8'h00;
    res = {5'h0, busy == 0, 9'h0} | {7'h00, rb};
    if (busy > 0) busy = busy - 1;
  endtask : take
  // States 4 to 7 form the data column, 8 to 11 the instruction one.
  always @(posedge tck) begin
    case (st)
      0: st <= tms ? 4'd0 : 4'd1;
      1: st <= tms ? 4'd2 : 4'd1;
      2: st <= tms ? 4'd3 : 4'd4;
      3: st <= tms ? 4'd0 : 4'd8;
      4, 8: begin
        n <= 0;
        out <= st[3] ? 1 : ir == 4'h5 ? res : {pg, 8'h5a};
        st <= st + (tms ? 4'd2 : 4'd1);
      end
      5, 9: begin
        sh[n] <= tdi;
        n <= n + 1;
        if (tms) st <= st + 4'd1;
      end
      6, 10: st <= tms ? st + 4'd1 : st - 4'd1;
      default: begin
        if (st[3]) ir <= sh[3:0];
        else if (ir == 4'hc) rst_reg <= sh[0];
        else if (ir == 4'h4) key <= sh[15:0];
        else if (ir == 4'h6 && en) pg <= sh[PB-1:0];
        else if (ir == 4'h5 && en) take(sh[14:0]);
        st <= tms ? 4'd2 : 4'd1;
      end
    endcase
  end
endmodule : jnpe_dev

// ### test/jnpe_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "jnpe_regs.svh"
// Runs every operation against the device model with random data.
module jnpe_ctrl_tb_top;
  logic clock = 0, reset_n = 0, cmd_valid = 0, fill_valid = 0;
  jnpe_pkg::jnpe_op_t cmd_op = jnpe_pkg::OP_ENTER;
  logic [15:0] cmd_arg = 16'h0, pg;
  logic [7:0] fill_data = 8'h0, a, b;
  logic [14:0] rsp_data, last_cmd;
  logic cmd_ready, rsp_valid, op_done, op_fail, fill_ready, fl;
  logic tck, tms, tdi, tdo, rst_reg, en;
  logic [31:0] r = 32'h8d21;
  logic [14:0] q[$];
  int fail_count = 0, checks_done = 0;
  always #4 clock = ~clock;
  jnpe_ctrl #(.PAGE_BITS(16), .WORD_BITS(3), .POLL_MAX(4)) uut (.clock,
    .reset_n, .cmd_valid, .cmd_op, .cmd_arg, .cmd_ready, .rsp_valid,
    .rsp_data, .op_done, .op_fail, .fill_valid, .fill_data, .fill_ready,
    .tck, .tms, .tdi, .tdo);
  jnpe_dev #(.PB(16)) dev (.tck, .tms, .tdi, .tdo, .rst_reg, .en,
    .last_cmd, .pg);
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lf
  // Ones in either lock write leave the bit as it was.
  function automatic logic [7:0] lkx(input logic [7:0] x, y);
    return {2'b11, x[5:0] & y[5:0]};
  endfunction : lkx
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  // One operation; answers are kept until op_done, bounded by a count.
  task automatic op(input jnpe_pkg::jnpe_op_t o, input logic [15:0] x);
    int k;
    k = 0;
    q = {};
    while (cmd_ready !== 1'b1) @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_arg <= x;
    @(posedge clock);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clock);
      if (rsp_valid === 1'b1) q.push_back(rsp_data);
    end while (op_done !== 1'b1 && k++ < 20000);
    if (op_done !== 1'b1) fail_count++;
    fl = op_fail;
  endtask : op
  task automatic fill(input logic [7:0] x);
    fill_valid <= 1'b1;
    fill_data <= x;
    do @(posedge clock); while (fill_ready !== 1'b1);
    fill_valid <= 1'b0;
    @(posedge clock);
  endtask : fill
  initial begin
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    op(jnpe_pkg::OP_ENTER, 16'h0);
    chk({14'h0, en, rst_reg}, 16'h3);
    op(jnpe_pkg::OP_PAGE_WRITE, 16'h0);
    chk({15'h0, fl}, 16'h1);
    op(jnpe_pkg::OP_ERASE, 16'h0);
    chk({fl, last_cmd}, {1'b0, `JNPE_W_ERASE_C});
    r = lf(r);
    fork
      op(jnpe_pkg::OP_PAGE_WRITE, r[15:0]);
      begin
        fill(r[7:0]);
        fill(r[15:8]);
      end
    join
    chk(pg, r[15:0]);
    chk({fl, last_cmd}, {1'b0, `JNPE_W_HI_A});
    op(jnpe_pkg::OP_PAGE_READ, r[15:0]);
    chk(16'(q.size()), 16'h2);
    chk({q[1][7:0], q[0][7:0]}, r[15:0]);
    r = lf(r);
    a = r[7:0];
    b = r[15:8];
    op(jnpe_pkg::OP_FUSE_HI, {8'h0, a});
    op(jnpe_pkg::OP_FUSE_LO, {8'h0, b});
    op(jnpe_pkg::OP_LOCK, {8'h0, a});
    op(jnpe_pkg::OP_LOCK, {8'h0, b});
    chk({fl, last_cmd}, {1'b0, `JNPE_W_LO_A});
    op(jnpe_pkg::OP_READ_FUSES, 16'h0);
    chk({q[0][7:0], q[1][7:0]}, {a, b});
    chk({8'h0, q[2][7:0]}, {8'h0, lkx(a, b)});
    for (int i = 0; i < 3; i++) begin
      r = lf(r);
      op(jnpe_pkg::OP_READ_SIG, {8'h0, r[7:0]});
      chk({8'h0, q[0][7:0]}, {8'h0, r[7:0] ^ 8'h5a});
    end
    op(jnpe_pkg::OP_READ_CAL, 16'h0);
    chk({8'h0, q[0][7:0]}, 16'h96);
    op(jnpe_pkg::OP_WORD, {1'b0, `JNPE_OP_ADDR_HI, r[15:8]});
    chk({1'b0, last_cmd}, {1'b0, `JNPE_OP_ADDR_HI, r[15:8]});
    op(jnpe_pkg::OP_LEAVE, 16'h0);
    chk({14'h0, en, rst_reg}, 16'h0);
    chk({1'b0, last_cmd}, {1'b0, `JNPE_W_NOP_B});
    results();
  end
  // Several times the expected run; a hang counts as a mismatch.
  initial begin
    #600000;
    fail_count++;
    results();
  end
endmodule : jnpe_ctrl_tb_top
